// [common/opmode_map.svh]
/*
 * register offsets, bit positions, reset values and threshold byte counts
 * for the operation mode control block.
 * assumes: included by bare name; definitions only.
 */
`ifndef OPMODE_MAP_SVH
`define OPMODE_MAP_SVH

// apb byte offsets
`define OFS_OPMODE 12'h000
`define OFS_ANEG 12'h004
`define OFS_STATUS 12'h008

// operation mode register fields
`define B_SCRAMBLE 24
`define B_PCS 23
`define B_TTM 22
`define B_SF 21
`define B_HBD 19
`define B_PORT 18
`define B_COE 17
`define B_THR_HI 15
`define B_THR_LO 14
`define B_TXRUN 13
`define B_FCOLL 12
`define B_LOOP_HI 11
`define B_LOOP_LO 10
`define B_FD 9
`define B_PM 7
`define B_PR 6
`define B_SB 5
`define B_INV 4
`define B_PB 3
`define B_HO 2
`define B_RXRUN 1
`define B_HP 0

// writable bits, hardware reset value, bits kept over a software reset
`define OPMODE_WMASK 32'h01EEFEEA
`define OPMODE_RST 32'h01800000
`define OPMODE_KEEP 32'h01040040

// autoneg control enable bit, status rx state field
`define B_ANEG_EN 7
`define B_RXST_LO 17

// transmit thresholds in bytes
`define THR100_0 11'h080
`define THR100_1 11'h100
`define THR100_2 11'h200
`define THR100_3 11'h400
`define THR10_0 11'h048
`define THR10_1 11'h060
`define THR10_2 11'h080
`define THR10_3 11'h0A0

// collisions that count as excessive
`define EXCESS_COLL 5'h10

`endif

// [common/opmode_pkg.sv]
/*
 * types for the operation mode control block.
 * assumes: offsets and fields come from opmode_map.svh.
 */
package opmode_pkg;
    // receive process states, coded onto the status field by function
    typedef enum logic [2:0] {
        RX_STOP, RX_FETCH, RX_CHECK, RX_WAIT, RX_SUSP, RX_CLOSE, RX_PURGE, RX_QUEUE
    } rx_state_t;
    // selected data port
    typedef enum logic [1:0] {PORT_NONE, PORT_ANEG, PORT_10BT, PORT_100TX} port_mode_t;
    // address filter modes
    typedef enum logic [2:0] {
        FLT_PERFECT16, FLT_HASH_ONE, FLT_HASH_ALL, FLT_INVERSE, FLT_PROMISC, FLT_ALLMC, FLT_OTHER
    } filter_mode_t;
    // transmit fifo fill report
    typedef struct packed {
        logic [10:0] bytes;
        logic full_frame;
    } txfifo_fill_t;
    // receive dma events
    typedef struct packed {
        logic desc_avail;
        logic poll;
        logic frame_start;
        logic chunk_done;
        logic frame_end;
        logic close_done;
    } rx_event_t;
endpackage

// [core/tx_start_gate.sv]
/*
 * decides when the transmitter may begin sending a frame from its fifo.
 * assumes: fifo fill report synchronous to the clock; one clock.
 */
`timescale 1ns/100ps
`include "opmode_map.svh"
module tx_start_gate
    import opmode_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_run,
    input wire logic i_store_forward,
    input wire logic i_tx_threshold_mode,
    input wire logic [1:0] i_threshold_code,
    input wire txfifo_fill_t i_fill,
    output logic o_start
);

    // threshold byte count for the mode and code
    function automatic logic [10:0] thr_bytes(input logic ten, input logic [1:0] code);
        case (code)
            2'h0: thr_bytes = ten ? `THR10_0 : `THR100_0;
            2'h1: thr_bytes = ten ? `THR10_1 : `THR100_1;
            2'h2: thr_bytes = ten ? `THR10_2 : `THR100_2;
            default: thr_bytes = ten ? `THR10_3 : `THR100_3;
        endcase
    endfunction

    logic over_thr; // fill strictly above threshold

    ////////////////////////////////////////////////////////////////////////
    // start decision
    always_comb begin
        over_thr = i_fill.bytes > thr_bytes(i_tx_threshold_mode, i_threshold_code);
    end

    // registered start; while running, whole frames go in either mode, short ones included
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_start <= 1'b0;
        end else if (!i_run) begin
            o_start <= 1'b0;
        end else if (i_store_forward) begin
            o_start <= i_fill.full_frame;
        end else begin
            o_start <= over_thr | i_fill.full_frame;
        end
    end

endmodule

// [core/mac_operation_mode_control.sv]
/*
 * operation mode control: apb registers for the operation mode word,
 * autoneg enable and receive state; drives mac and phy configuration,
 * the receive process state machine and the transmit start gate.
 * assumes: one 250 MHz clock, synchronous active-high reset, apb master,
 * dma and mac event inputs synchronous to the clock.
 */
//
// Overview of operation
// - rx codes 000 stop/fetch, 010, 011
// - rx codes 100, 101, 110, 111 as listed
// - bit 24 scrambler, default set, soft-kept
// - bit 23 coding sublayer; symbols need bit18
// - store-forward waits for whole frame
// - bit 19 disables heartbeat in 10 mode
// - bit 18 picks 100; reset 0, soft-kept
// - bit 17 selects modified backoff
// - threshold bytes by bits 15:14
// - bit 22 picks 10 threshold set
// - bit 13 runs or stops transmit
// - bits 11:10 pick loopback mode
// - full duplex: no heartbeat, no internal loop
// - bit 7 passes all multicast
// - bit 6 promiscuous, clear, soft-kept
// - bit 5 gates backoff on carrier
// - bit 3 passes bad frames
// - bits 4,2,0 are read-only filter flags
// - filter bits decode to filter mode
// - port chosen from aneg, 18, 22, 23, 24
// - autoneg control bit 7 enables autoneg
`timescale 1ns/100ps
`include "opmode_map.svh"
module mac_operation_mode_control
    import opmode_pkg::*;
(
    input wire logic I_CLK,
    input wire logic I_RESET,
    input wire logic I_SOFT_RESET,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [11:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    input wire logic I_FILT_INVERSE,
    input wire logic I_FILT_HASH_ONLY,
    input wire logic I_FILT_HASH_MC,
    input wire rx_event_t I_RX_EVT,
    input wire txfifo_fill_t I_TX_FILL,
    input wire logic I_CARRIER,
    input wire logic I_COLLISION,
    input wire logic I_TX_ATTEMPT_DONE,
    output logic O_TX_START,
    output logic O_TX_RUN,
    output logic O_RX_RUN,
    output logic [2:0] O_RX_STATE,
    output logic O_SCRAMBLE_EN,
    output logic O_PCS_EN,
    output logic O_SYMBOL_MODE,
    output logic O_HEARTBEAT_EN,
    output logic O_BACKOFF_MODIFIED,
    output logic O_BACKOFF_HOLD,
    output logic [1:0] O_LOOPBACK_SEL,
    output logic O_FORCE_COLLIDE,
    output logic O_LINK_WORD_FD,
    output logic O_BAD_FRAME_PASS,
    output port_mode_t O_PORT_MODE,
    output filter_mode_t O_FILTER_MODE,
    output logic O_EXCESS_COLL
);

    // status code for each receive state
    function automatic logic [2:0] rx_code(input rx_state_t s);
        case (s)
            RX_CHECK: rx_code = 3'h2;
            RX_WAIT: rx_code = 3'h3;
            RX_SUSP: rx_code = 3'h4;
            RX_CLOSE: rx_code = 3'h5;
            RX_PURGE: rx_code = 3'h6;
            RX_QUEUE: rx_code = 3'h7;
            default: rx_code = 3'h0; // stopped or fetching
        endcase
    endfunction

    // register decode
    function automatic logic map_hit(input logic [11:0] a);
        map_hit = (a == `OFS_OPMODE) || (a == `OFS_ANEG) || (a == `OFS_STATUS);
    endfunction

    logic [31:0] opmode_q; // writable part of operation mode word
    logic aneg_en_q; // autoneg enable
    logic [2:0] filt_q; // read-only filter flags: inv, ho, hp
    rx_state_t rx_q; // receive process state
    rx_state_t rx_d;
    logic [4:0] coll_cnt_q; // collisions this attempt
    logic setup_ph; // apb setup cycle
    logic wr_op; // write to operation mode taken
    logic [31:0] opmode_rd; // read view of operation mode
    logic loop_internal; // requested loopback is internal
    logic fd; // full duplex

    assign setup_ph = I_PSEL & ~I_PENABLE;
    assign wr_op = I_PSEL & I_PENABLE & O_PREADY & I_PWRITE & (I_PADDR == `OFS_OPMODE);
    assign fd = opmode_q[`B_FD];
    assign loop_internal = opmode_q[`B_LOOP_LO];

    // reserved bits zero, filter flags merged in
    always_comb begin
        opmode_rd = opmode_q & `OPMODE_WMASK;
        opmode_rd[`B_INV] = filt_q[2];
        opmode_rd[`B_HO] = filt_q[1];
        opmode_rd[`B_HP] = filt_q[0];
    end

    ////////////////////////////////////////////////////////////////////////
    // apb slave: zero wait states, answer ready in the access cycle
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            O_PREADY <= 1'b0;
            O_PSLVERR <= 1'b0;
            O_PRDATA <= 32'h00000000;
        end else if (setup_ph) begin
            O_PREADY <= 1'b1;
            O_PSLVERR <= ~map_hit(I_PADDR);
            // unmapped and write reads return zero
            if (I_PWRITE || !map_hit(I_PADDR)) begin
                O_PRDATA <= 32'h00000000;
            end else if (I_PADDR == `OFS_OPMODE) begin
                O_PRDATA <= opmode_rd;
            end else if (I_PADDR == `OFS_ANEG) begin
                O_PRDATA <= {24'h000000, aneg_en_q, 7'h00};
            end else begin
                O_PRDATA <= {12'h000, rx_code(rx_q), 17'h00000};
            end
        end else begin
            O_PREADY <= 1'b0;
            O_PSLVERR <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // operation mode word; software reset spares the kept bits
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            opmode_q <= `OPMODE_RST;
        end else if (I_SOFT_RESET) begin
            opmode_q <= (opmode_q & `OPMODE_KEEP) | (`OPMODE_RST & ~`OPMODE_KEEP);
        end else if (wr_op) begin
            opmode_q <= I_PWDATA & `OPMODE_WMASK;
        end
    end

    // autoneg enable bit
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            aneg_en_q <= 1'b0;
        end else if (I_PSEL && I_PENABLE && O_PREADY && I_PWRITE && I_PADDR == `OFS_ANEG) begin
            aneg_en_q <= I_PWDATA[`B_ANEG_EN];
        end
    end

    // filter flags follow the setup-frame logic, never software
    always_ff @(posedge I_CLK) begin
        if (I_RESET || I_SOFT_RESET) begin
            filt_q <= 3'h0;
        end else begin
            filt_q <= {I_FILT_INVERSE, I_FILT_HASH_ONLY, I_FILT_HASH_MC};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // receive process next state
    always_comb begin
        rx_d = rx_q;
        case (rx_q)
            RX_STOP: begin
                if (opmode_q[`B_RXRUN]) rx_d = RX_FETCH;
            end
            RX_FETCH: begin
                // stop only between frames
                if (!opmode_q[`B_RXRUN]) rx_d = RX_STOP;
                else if (I_RX_EVT.desc_avail) rx_d = RX_WAIT;
                else rx_d = RX_SUSP;
            end
            RX_WAIT: begin
                if (!opmode_q[`B_RXRUN]) rx_d = RX_STOP;
                else if (I_RX_EVT.frame_start) rx_d = RX_QUEUE;
            end
            RX_QUEUE: begin
                if (I_RX_EVT.chunk_done) rx_d = RX_CHECK;
            end
            RX_CHECK: begin
                if (I_RX_EVT.frame_end) rx_d = RX_CLOSE;
                else rx_d = RX_QUEUE;
            end
            RX_CLOSE: begin
                if (I_RX_EVT.close_done) rx_d = RX_FETCH;
            end
            RX_SUSP: begin
                // poll or new frame retries the descriptor
                if (!opmode_q[`B_RXRUN]) rx_d = RX_STOP;
                else if (I_RX_EVT.poll) rx_d = RX_FETCH;
                else if (I_RX_EVT.frame_start) rx_d = I_RX_EVT.desc_avail ? RX_QUEUE : RX_PURGE;
            end
            RX_PURGE: begin
                if (I_RX_EVT.frame_end) rx_d = RX_SUSP;
            end
            default: rx_d = RX_STOP;
        endcase
    end

    // receive state register
    always_ff @(posedge I_CLK) begin
        if (I_RESET || I_SOFT_RESET) begin
            rx_q <= RX_STOP;
        end else begin
            rx_q <= rx_d;
        end
    end

    // exported state code
    always_ff @(posedge I_CLK) begin
        if (I_RESET || I_SOFT_RESET) begin
            O_RX_STATE <= 3'h0;
        end else begin
            O_RX_STATE <= rx_code(rx_d);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // transmit start gate
    tx_start_gate u_gate (
        .i_clk(I_CLK),
        .i_reset(I_RESET),
        .i_run(opmode_q[`B_TXRUN]),
        .i_store_forward(opmode_q[`B_SF]),
        .i_tx_threshold_mode(opmode_q[`B_TTM]),
        .i_threshold_code(opmode_q[`B_THR_HI:`B_THR_LO]),
        .i_fill(I_TX_FILL),
        .o_start(O_TX_START)
    );

    // collision count per attempt; saturates at the excessive mark
    always_ff @(posedge I_CLK) begin
        if (I_RESET || I_TX_ATTEMPT_DONE) begin
            coll_cnt_q <= 5'h00;
        end else if ((I_COLLISION || O_FORCE_COLLIDE) && coll_cnt_q != `EXCESS_COLL) begin
            coll_cnt_q <= coll_cnt_q + 5'h01;
        end
    end

    // excessive collision flag for descriptor status bit 8
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            O_EXCESS_COLL <= 1'b0;
        end else if (I_TX_ATTEMPT_DONE) begin
            O_EXCESS_COLL <= (coll_cnt_q == `EXCESS_COLL);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // mac and phy configuration outputs
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            O_TX_RUN <= 1'b0;
            O_RX_RUN <= 1'b0;
            O_SCRAMBLE_EN <= 1'b1;
            O_PCS_EN <= 1'b1;
            O_SYMBOL_MODE <= 1'b0;
            O_HEARTBEAT_EN <= 1'b0;
            O_BACKOFF_MODIFIED <= 1'b0;
            O_BACKOFF_HOLD <= 1'b0;
            O_LOOPBACK_SEL <= 2'h0;
            O_FORCE_COLLIDE <= 1'b0;
            O_LINK_WORD_FD <= 1'b0;
            O_BAD_FRAME_PASS <= 1'b0;
        end else begin
            O_TX_RUN <= opmode_q[`B_TXRUN];
            O_RX_RUN <= opmode_q[`B_RXRUN];
            O_SCRAMBLE_EN <= opmode_q[`B_SCRAMBLE];
            O_PCS_EN <= opmode_q[`B_PCS];
            O_SYMBOL_MODE <= opmode_q[`B_PCS] & opmode_q[`B_PORT];
            // heartbeat only in 10 half duplex with sqe left on
            O_HEARTBEAT_EN <= ~opmode_q[`B_PORT] & ~opmode_q[`B_HBD] & ~fd;
            O_BACKOFF_MODIFIED <= opmode_q[`B_COE];
            // carrier pauses the backoff timer only when gated
            O_BACKOFF_HOLD <= opmode_q[`B_SB] & I_CARRIER;
            // internal loopback refused under full duplex
            O_LOOPBACK_SEL <= (fd && loop_internal) ? 2'h0 : opmode_q[`B_LOOP_HI:`B_LOOP_LO];
            // forced collisions only while looped inside
            O_FORCE_COLLIDE <= opmode_q[`B_FCOLL] & loop_internal & ~fd & O_TX_START;
            O_LINK_WORD_FD <= fd;
            O_BAD_FRAME_PASS <= opmode_q[`B_PB];
        end
    end

    // port selection; undefined combinations report none
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            O_PORT_MODE <= PORT_NONE;
        end else if (aneg_en_q && !opmode_q[`B_PORT] && opmode_q[`B_SCRAMBLE]) begin
            O_PORT_MODE <= PORT_ANEG;
        end else if (!aneg_en_q && !opmode_q[`B_PORT] && opmode_q[`B_TTM] && !opmode_q[`B_SCRAMBLE]) begin
            O_PORT_MODE <= PORT_10BT;
        end else if (!aneg_en_q && opmode_q[`B_PORT] && !opmode_q[`B_TTM] && opmode_q[`B_PCS]) begin
            O_PORT_MODE <= PORT_100TX;
        end else begin
            O_PORT_MODE <= PORT_NONE;
        end
    end

    // filter mode from pm, pr, inv, ho, hp
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            O_FILTER_MODE <= FLT_PERFECT16;
        end else begin
            case ({opmode_q[`B_PM], opmode_q[`B_PR], filt_q})
                5'b00000: O_FILTER_MODE <= FLT_PERFECT16;
                5'b00001: O_FILTER_MODE <= FLT_HASH_ONE;
                5'b00011: O_FILTER_MODE <= FLT_HASH_ALL;
                5'b00100: O_FILTER_MODE <= FLT_INVERSE;
                5'b01000, 5'b01001, 5'b11000, 5'b11001, 5'b01011: O_FILTER_MODE <= FLT_PROMISC;
                5'b10000, 5'b10001, 5'b10011: O_FILTER_MODE <= FLT_ALLMC;
                default: O_FILTER_MODE <= FLT_OTHER;
            endcase
        end
    end

endmodule

// [tb/mac_opmode_props.sv]
/* assertions on the ports of the operation mode block.
   assumes: bound onto mac_operation_mode_control; one clock, sync reset. */
`timescale 1ns/100ps
`include "opmode_map.svh"
module mac_opmode_props (
    input wire logic I_CLK,
    input wire logic I_RESET,
    input wire logic I_SOFT_RESET,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [11:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    input wire logic I_CARRIER,
    input wire logic O_PREADY,
    input wire logic O_TX_RUN,
    input wire logic O_RX_RUN,
    input wire logic O_SCRAMBLE_EN,
    input wire logic O_PCS_EN,
    input wire logic O_SYMBOL_MODE,
    input wire logic O_HEARTBEAT_EN,
    input wire logic O_BACKOFF_HOLD,
    input wire logic [1:0] O_LOOPBACK_SEL,
    input wire logic O_LINK_WORD_FD
);
    default clocking @(posedge I_CLK); endclocking
    default disable iff (I_RESET);
    ////////////////////////////////////////////////////////////////
    // completed mode word write; a racing soft reset is left out
    logic wop;
    assign wop = I_PSEL & I_PENABLE & O_PREADY & I_PWRITE & !I_SOFT_RESET & (I_PADDR == `OFS_OPMODE);
    // config outputs lag the register by a cycle, hence two edges
    a_tx_run_follow: assert property (wop |-> ##2 O_TX_RUN == $past(I_PWDATA[13], 2))
        else $error("transmit run flag did not follow the write");
    a_rx_run_follow: assert property (wop |-> ##2 O_RX_RUN == $past(I_PWDATA[1], 2))
        else $error("receive run flag did not follow the write");
    a_scramble_follow: assert property (wop |-> ##2 O_SCRAMBLE_EN == $past(I_PWDATA[24], 2))
        else $error("scrambler enable did not follow the write");
    a_symbol_needs_port: assert property (wop |-> ##2 O_SYMBOL_MODE ==
        ($past(I_PWDATA[23], 2) && $past(I_PWDATA[18], 2)))
        else $error("symbol mode wrong for coding sublayer and port");
    a_loop_select: assert property (wop |-> ##2 O_LOOPBACK_SEL ==
        (($past(I_PWDATA[9], 2) && $past(I_PWDATA[10], 2)) ? 2'h0 : $past(I_PWDATA[11:10], 2)))
        else $error("loopback select wrong");
    a_duplex_no_loop: assert property (O_LINK_WORD_FD |-> !O_HEARTBEAT_EN && !O_LOOPBACK_SEL[0])
        else $error("full duplex with heartbeat or internal loopback");
    a_backoff_carrier: assert property (O_BACKOFF_HOLD |-> $past(I_CARRIER))
        else $error("backoff hold without carrier");
    a_soft_tx_stop: assert property (I_SOFT_RESET && !wop |-> ##2 !O_TX_RUN && O_PCS_EN)
        else $error("soft reset left transmit running or sublayer off");
endmodule

bind mac_operation_mode_control mac_opmode_props mac_opmode_props_inst (.*);

// [tb/mac_far_side.sv]
/* far-side model: receive dma events, one frame per request.
   assumes: shares the block's clock; events change just after an edge. */
`timescale 1ns/100ps
module mac_far_side
    import opmode_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_go,
    input wire logic i_buf_ok,
    output rx_event_t o_rx_evt
);
    logic [3:0] step_q; // frame progress, 0 is idle
    ////////////////////////////////////////////////////////////////
    // step counter; wraps to idle, so events never repeat unasked
    always_ff @(posedge i_clk) begin
        if (i_reset || i_go) begin
            step_q <= i_go ? 4'h1 : 4'h0;
        end else if (step_q != 4'h0) begin
            step_q <= step_q + 4'h1;
        end
    end
    // one-cycle pulses; frame end right after chunk done, since the check state looks only once
    assign o_rx_evt = '{desc_avail: i_buf_ok, poll: 1'h0, frame_start: step_q == 4'h3,
        chunk_done: step_q == 4'h6, frame_end: step_q == 4'h7, close_done: step_q == 4'hC};
endmodule

// [tb/mac_operation_mode_control_tb.sv]
/* self-checking bench for the operation mode block.
   assumes: far-side model in mac_far_side; checker bound in its own file. */
`timescale 1ns/100ps
`include "opmode_map.svh"
module mac_operation_mode_control_tb
    import opmode_pkg::*;
;
    logic clk = 0, rst = 1, srst = 0, psel = 0, pen = 0, pwr = 0, fi = 0, fh = 0, fm = 0, car = 0;
    logic col = 0, dn = 0, go = 0, buf_ok = 1, rerr, prdy, perr, tx_start, tx_run, rx_run, hb, bom, fdw, bfp, exc;
    logic [11:0] pa = 12'h000;
    logic [31:0] pwd = 32'h0, rd, prdata, v, e, rs = 32'h2B; // lfsr seed 43
    logic [2:0] rxs;
    logic fc, bho; // forced collision, backoff hold
    logic [32:0] hist = 33'h0; // receive state codes, newest lowest
    txfifo_fill_t fill = '0;
    rx_event_t evt;
    port_mode_t pm;
    filter_mode_t fmode;
    int n_mismatch = 0, n_tests = 0, cyc = 0;
    ////////////////////////////////////////////////////////////////
    mac_operation_mode_control mac_operation_mode_control_inst (
        .I_CLK(clk), .I_RESET(rst), .I_SOFT_RESET(srst), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
        .I_PADDR(pa), .I_PWDATA(pwd), .O_PRDATA(prdata), .O_PREADY(prdy), .O_PSLVERR(perr),
        .I_FILT_INVERSE(fi), .I_FILT_HASH_ONLY(fh), .I_FILT_HASH_MC(fm), .I_RX_EVT(evt), .I_TX_FILL(fill),
        .I_CARRIER(car), .I_COLLISION(col), .I_TX_ATTEMPT_DONE(dn), .O_TX_START(tx_start), .O_TX_RUN(tx_run),
        .O_RX_RUN(rx_run), .O_RX_STATE(rxs), .O_SCRAMBLE_EN(), .O_PCS_EN(), .O_SYMBOL_MODE(),
        .O_HEARTBEAT_EN(hb), .O_BACKOFF_MODIFIED(bom), .O_BACKOFF_HOLD(bho), .O_LOOPBACK_SEL(),
        .O_FORCE_COLLIDE(fc), .O_LINK_WORD_FD(fdw), .O_BAD_FRAME_PASS(bfp), .O_PORT_MODE(pm),
        .O_FILTER_MODE(fmode), .O_EXCESS_COLL(exc)
    );
    mac_far_side mac_far_side_inst (.i_clk(clk), .i_reset(rst), .i_go(go), .i_buf_ok(buf_ok), .o_rx_evt(evt));
    ////////////////////////////////////////////////////////////////
    initial forever #2 clk = ~clk;
    // record each change of the receive state code
    always @(posedge clk) begin
        if (rxs !== hist[2:0]) hist <= {hist[29:0], rxs};
    end
    // hang guard, far above the real run length
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_mismatch++;
            results();
        end
    end
    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // threshold bytes by mode and code
    function automatic logic [10:0] thr(input logic tx_threshold_mode, input logic [1:0] c);
        logic [10:0] t10 [4] = '{11'h048, 11'h060, 11'h080, 11'h0A0};
        logic [10:0] t100 [4] = '{11'h080, 11'h100, 11'h200, 11'h400};
        return tx_threshold_mode ? t10[c] : t100[c];
    endfunction
    // filter bits 7,6,4,2,0 to mode
    function automatic filter_mode_t flt(input logic [31:0] o);
        logic [4:0] b;
        b = {o[7], o[6], o[4], o[2], o[0]};
        if (b == 5'h00) return FLT_PERFECT16;
        if (b == 5'h01) return FLT_HASH_ONE;
        if (b == 5'h03) return FLT_HASH_ALL;
        if (b == 5'h04) return FLT_INVERSE;
        if (b[3:1] == 3'h4 || b == 5'h0B) return FLT_PROMISC;
        if (b[4:1] == 4'h8 || b == 5'h13) return FLT_ALLMC;
        return FLT_OTHER;
    endfunction
    function automatic port_mode_t prt(input logic an, input logic [31:0] o);
        if (an && !o[18] && o[24]) return PORT_ANEG;
        if (!an && !o[18] && o[22] && !o[24]) return PORT_10BT;
        if (!an && o[18] && !o[22] && o[23]) return PORT_100TX;
        return PORT_NONE;
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // one apb transfer, entered just after an edge; waits for ready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'h1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'h1;
        do @(posedge clk); while (prdy !== 1'h1);
        rd = prdata;
        rerr = perr;
        psel <= 1'h0;
        pen <= 1'h0;
        @(posedge clk);
    endtask
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        n_tests++;
        if (g !== x) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, x, g);
        end
    endtask
    task automatic results();
        if (n_mismatch == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        tick(3);
        rst <= 1'h0;
        tick(1);
        apb(0, `OFS_OPMODE, 0);
        chk("op reset", 32'h01800000, rd);
        apb(0, 12'h00C, 0);
        chk("unmapped", 32'h1, {rd[30:0], rerr});
        apb(1, `OFS_STATUS, 32'hFFFFFFFF);
        apb(0, `OFS_STATUS, 0);
        chk("status", 32'h0, rd);
        // random mode words, filter flags, carrier and autoneg enable
        for (int i = 0; i < 64; i++) begin
            rs = nxt(rs);
            v = rs;
            {fi, fh, fm, car} <= v[31:28];
            apb(1, `OFS_ANEG, {24'h0, v[27], 7'h0});
            apb(0, `OFS_ANEG, 0);
            chk("aneg", {24'h0, v[27], 7'h0}, rd);
            apb(1, `OFS_OPMODE, v);
            apb(0, `OFS_OPMODE, 0);
            e = (v & 32'h01EEFEEA) | {27'h0, v[31], 1'h0, v[30], 1'h0, v[29]};
            chk("op word", e, rd);
            chk("port", 32'(prt(v[27], e)), 32'(pm));
            chk("filter", 32'(flt(e)), 32'(fmode));
            chk("heartbeat", 32'(!e[18] & !e[19] & !e[9]), 32'(hb));
            chk("misc", 32'({e[17], e[3], e[9], e[13], e[1]}), 32'({bom, bfp, fdw, tx_run, rx_run}));
            chk("backoff hold", 32'(e[5] & v[28]), 32'(bho));
        end
        // soft reset keeps scrambler, port select and promiscuous only
        {fi, fh, fm} <= 3'h0;
        apb(1, `OFS_OPMODE, 32'hFFFFFFFF);
        srst <= 1'h1;
        tick(1);
        srst <= 1'h0;
        apb(0, `OFS_OPMODE, 0);
        chk("soft keep", 32'h01840040, rd);
        // fifteen then sixteen collisions in one attempt
        for (int n = 15; n < 17; n++) begin
            col <= 1'h1;
            tick(n);
            col <= 1'h0;
            dn <= 1'h1;
            tick(1);
            dn <= 1'h0;
            tick(1);
            chk("excess", 32'(n > 15), 32'(exc));
        end
        // threshold boundary: equal holds, one byte more starts
        for (int k = 0; k < 8; k++) begin
            apb(1, `OFS_OPMODE, {9'h0, k[2], 6'h0, k[1:0], 14'h2000});
            for (int j = 0; j < 2; j++) begin
                fill <= '{bytes: thr(k[2], k[1:0]) + 11'(j), full_frame: 1'h0};
                tick(2);
                chk("tx start", 32'(j), 32'(tx_start));
            end
        end
        apb(1, `OFS_OPMODE, 32'h00202000);
        fill <= '{bytes: 11'h7FF, full_frame: 1'h0};
        tick(2);
        chk("sf part", 32'h0, 32'(tx_start));
        fill.full_frame <= 1'h1;
        tick(2);
        chk("sf full", 32'h1, 32'(tx_start));
        // start pending in fifo loopback: half duplex forces collisions, full duplex must not
        apb(1, `OFS_OPMODE, 32'h00203400);
        tick(1);
        chk("force coll", 32'h1, 32'(fc));
        apb(1, `OFS_OPMODE, 32'h00203600);
        tick(1);
        chk("force coll fd", 32'h0, 32'(fc));
        // one frame with a buffer, one without, stopping after each
        fill <= '0;
        for (int f = 0; f < 2; f++) begin
            apb(1, `OFS_OPMODE, 32'h0);
            buf_ok <= f == 0;
            apb(1, `OFS_OPMODE, 32'h2);
            tick(3);
            go <= 1'h1;
            tick(1);
            go <= 1'h0;
            tick(20);
        end
        apb(1, `OFS_OPMODE, 32'h0);
        tick(3);
        chk("rx early", 32'({3'h3, 3'h7, 3'h2, 3'h5, 3'h0}), 32'(hist[32:18]));
        chk("rx late", 32'({3'h3, 3'h0, 3'h4, 3'h6, 3'h4, 3'h0}), 32'(hist[17:0]));
        results();
    end
endmodule
